// ==== verilog/csbi_pkg.sv ====
// Constants and types for the processor system bus interface block
// Assumes a single system clock; the input clock of the device is clk_sys
// Function
// - Divide input clock by two into phases
// - Align low freezes bus clock low
// - Align high restarts bus clock high, toggles
// - Reset aborts work, clears pending events
// - Save counter and status into registers
// - Clear control registers, restart at zero
// - Reset drives strobes inactive, floats data
// - Pending bus request acknowledged before cycles
// - Idle status codes on five pins
// - Interrupt acknowledge and end codes
// - Fetch, data and table entry codes
// - Slave processor cycle status codes
// - Two-state cycle, strobe in first half
// - Commit strobe mid first state
// - Cancel keeps commit high, transaction low for first state only
// - Committed cycle ends after second state
// - Read data captured, dropped on exception
// - Write data held until next mid-T1 or an idle state with no cycle or hold request
// - Idle state between read and write
// - Cache block select on cacheable block reads
// - Ready sampled each second state, waits
package csbi_pkg;

  // ****************************************
  // Status codes
  // ****************************************
  localparam logic [4:0] ST_IDLE     = 5'h00;
  localparam logic [4:0] ST_WAITINT  = 5'h01;
  localparam logic [4:0] ST_HALTED   = 5'h02;
  localparam logic [4:0] ST_WAITSLV  = 5'h03;
  localparam logic [4:0] ST_IACK_M   = 5'h04;
  localparam logic [4:0] ST_IACK_C   = 5'h05;
  localparam logic [4:0] ST_EOI_M    = 5'h06;
  localparam logic [4:0] ST_EOI_C    = 5'h07;
  localparam logic [4:0] ST_FETCH_S  = 5'h08;
  localparam logic [4:0] ST_FETCH_N  = 5'h09;
  localparam logic [4:0] ST_DATA     = 5'h0A;
  localparam logic [4:0] ST_RMW      = 5'h0B;
  localparam logic [4:0] ST_EAPTR    = 5'h0C;
  localparam logic [4:0] ST_TE_ONE   = 5'h0D;
  localparam logic [4:0] ST_TE_TWO   = 5'h0E;
  localparam logic [4:0] ST_SLV_OPND = 5'h1D;
  localparam logic [4:0] ST_SLV_STAT = 5'h1E;
  localparam logic [4:0] ST_SLV_BCST = 5'h1F;

  // ****************************************
  // Reset values and figures
  // ****************************************
  localparam logic [31:0] PC_RESET     = 32'h0000_0000;
  localparam logic [15:0] PSW_RESET    = 16'h0000;
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;
  localparam int          RST_MIN_BCLK = 64;
  localparam int          ALIGN_MIN_CLK = 128;

  // ****************************************
  // Avalon register map, word byte addresses
  // ****************************************
  localparam logic [5:0] A_CTRL    = 6'h00;
  localparam logic [5:0] A_ADDR    = 6'h04;
  localparam logic [5:0] A_WDATA   = 6'h08;
  localparam logic [5:0] A_STAT    = 6'h0C;
  localparam logic [5:0] A_RDATA   = 6'h10;
  localparam logic [5:0] A_PC      = 6'h14;
  localparam logic [5:0] A_GR0     = 6'h18;
  localparam logic [5:0] A_GR1     = 6'h1C;
  localparam logic [5:0] A_PSW     = 6'h20;
  localparam logic [5:0] A_TSR     = 6'h24;
  localparam logic [5:0] A_TCR     = 6'h28;
  localparam logic [5:0] A_CFG     = 6'h2C;
  localparam logic [5:0] A_DCR     = 6'h30;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hDEAD_BEEF;

  // CTRL fields
  localparam int C_GO     = 0;
  localparam int C_WRITE  = 1;
  localparam int C_CANCEL = 2;
  localparam int C_CACHE  = 3;
  localparam int C_BLOCK  = 4;
  localparam int C_CODE   = 8;
  localparam int C_IDLE   = 16;
  localparam int C_BE     = 24;
  // STAT fields
  localparam int S_BUSY   = 0;
  localparam int S_DONE   = 1;
  localparam int S_BERR   = 2;
  localparam int S_GRANT  = 3;
  localparam int DEN_BIT  = 0;

  // ****************************************
  // Bus state machine
  // ****************************************
  typedef enum logic [4:0] {
    BS_IDLE = 5'b00001,
    BS_T1   = 5'b00010,
    BS_T2   = 5'b00100,
    BS_TI   = 5'b01000,
    BS_HOLD = 5'b10000
  } csbi_bus_t;

endpackage : csbi_pkg

// ==== verilog/csbi_top.sv ====
// Processor system interface: bus clock divider, reset, two-state bus cycles
// Assumes Avalon-MM master for software, memory side answers with readyN
`timescale 1ns/1ps
`default_nettype none
module csbi_top
  import csbi_pkg::*;
(
  input  wire  logic        clk_sys,
  input  wire  logic        rstn,
  input  wire  logic        alignN,
  input  wire  logic        cpuResetN,
  input  wire  logic        busReqN,
  input  wire  logic        readyN,
  input  wire  logic        busErrN,
  input  wire  logic [31:0] dataIn,
  output logic              busClk,
  output logic              busClkN,
  output logic              internal_phase_a,
  output logic              internal_phase_b,
  output logic [31:0]       addrOut,
  output logic [31:0]       dataOut,
  output logic              dataOeN,
  output logic              address_strobeN,
  output logic [3:0]        byte_lane_enablesN,
  output logic              begin_memory_transactionN,
  output logic              cycle_commit_strobeN,
  output logic              bus_grant_ackN,
  output logic [4:0]        bus_cycle_status,
  output logic              cache_block_select,
  output logic              writeEnN,
  input  wire  logic [5:0]  avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [31:0] avs_writedata,
  input  wire  logic [3:0]  avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rstSyncQ;
  logic       rstnS;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rstSyncQ <= 2'h0;
    else
      rstSyncQ <= {rstSyncQ[0], 1'b1};
  end
  assign rstnS = rstSyncQ[1];

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic        bclk;
    logic        rdAck;
    logic        rstSeen;
    csbi_bus_t   bs;
    logic        lastRead;
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] drive;
    logic        busy;
    logic        done;
    logic        berr;
    logic        grant;
    logic [31:0] pc;
    logic [31:0] gr0;
    logic [31:0] gr1;
    logic [15:0] psw;
    logic [31:0] tsr;
    logic [31:0] tcr;
    logic [31:0] cfg;
    logic [31:0] debug_control_register;
    logic        dOe;
    logic        address_strobe;
    logic        cycle_commit_strobe;
    logic        begin_memory_transaction;
    logic [4:0]  st;
  } csbi_state_t;

  csbi_state_t q, d;
  logic bclkRise;
  logic bclkFall;
  logic inReset;
  logic avAcc;
  assign bclkRise = !q.bclk && alignN;
  assign bclkFall = q.bclk;
  assign inReset  = !cpuResetN;
  assign avAcc    = (avs_read || avs_write) && !q.rdAck;

  always_comb
  begin
    d = q;
    d.rdAck = 1'b0;
    // Bus clock divider and alignment
    if (!alignN)
      d.bclk = 1'b0;
    else
      d.bclk = !q.bclk;
    // Register port, write lands on the edge with waitrequest low
    d.rdAck = avAcc;
    if (avs_write && q.rdAck)
    begin
      case (avs_address)
        A_CTRL:  d.ctrl  = avs_writedata;
        A_ADDR:  d.addr  = avs_writedata;
        A_WDATA: d.wdata = avs_writedata;
        A_PC:    d.pc    = avs_writedata;
        A_PSW:   d.psw   = avs_writedata[15:0];
        A_TSR:   d.tsr   = avs_writedata;
        A_TCR:   d.tcr   = avs_writedata;
        A_CFG:   d.cfg   = avs_writedata;
        A_DCR:   d.debug_control_register   = avs_writedata;
        A_STAT:
        begin
          if (avs_writedata[S_DONE])
            d.done = 1'b0;
          if (avs_writedata[S_BERR])
            d.berr = 1'b0;
        end
        default: d.ctrl = q.ctrl;
      endcase
    end
    // Write data launched in the middle of the first state
    if (bclkFall && q.bs == BS_T1)
    begin
      d.dOe   = q.ctrl[C_WRITE];
      d.drive = q.ctrl[C_WRITE] ? q.wdata : q.drive;
    end
    // Bus sequencing on bus clock rising edge
    if (bclkRise)
    begin
      if (inReset)
      begin
        if (!q.rstSeen)
        begin
          d.gr0 = q.pc;
          d.gr1 = {q.gr1[31:16], q.psw};
        end
        d.rstSeen = 1'b1;
        d.pc   = PC_RESET;
        d.psw  = PSW_RESET;
        d.tsr  = REG_RESET;
        d.tcr  = REG_RESET;
        d.cfg  = REG_RESET;
        d.debug_control_register[DEN_BIT] = 1'b0;
        d.bs   = BS_IDLE;
        d.ctrl[C_GO] = 1'b0;
        d.busy = 1'b0;
        d.berr = 1'b0;
        d.address_strobe  = 1'b0;
        d.cycle_commit_strobe = 1'b0;
        d.begin_memory_transaction  = 1'b0;
        d.dOe  = 1'b0;
        d.grant = 1'b0;
        d.st   = ST_IDLE;
      end
      else
      begin
        d.rstSeen = 1'b0;
        d.address_strobe = 1'b0;
        case (q.bs)
          BS_IDLE, BS_HOLD:
          begin
            d.cycle_commit_strobe = 1'b0;
            d.begin_memory_transaction  = 1'b0;
            if (!busReqN)
            begin
              d.bs = BS_HOLD;
              d.grant = 1'b1;
            end
            else if (q.ctrl[C_GO])
            begin
              d.grant = 1'b0;
              d.ctrl[C_GO] = 1'b0;
              d.busy = 1'b1;
              d.st = q.ctrl[C_CODE +: 5];
              if (q.ctrl[C_WRITE] && q.lastRead)
                d.bs = BS_TI;
              else
              begin
                d.bs  = BS_T1;
                d.address_strobe = 1'b1;
                d.begin_memory_transaction = 1'b1;
                d.cycle_commit_strobe = !q.ctrl[C_CANCEL];
              end
            end
            else
            begin
              d.grant = 1'b0;
              d.st = q.ctrl[C_IDLE +: 5];
              d.dOe = 1'b0;
            end
          end
          BS_TI:
          begin
            d.bs  = BS_T1;
            d.address_strobe = 1'b1;
            d.begin_memory_transaction = 1'b1;
            d.cycle_commit_strobe = !q.ctrl[C_CANCEL];
            d.lastRead = 1'b0;
          end
          BS_T1:
          begin
            if (!q.cycle_commit_strobe)
            begin
              d.begin_memory_transaction  = 1'b0;
              d.busy = 1'b0;
              d.done = 1'b1;
              d.bs   = BS_IDLE;
            end
            else
              d.bs = BS_T2;
          end
          BS_T2:
          begin
            if (!readyN)
            begin
              d.bs   = BS_IDLE;
              d.busy = 1'b0;
              d.done = 1'b1;
              d.cycle_commit_strobe = 1'b0;
              d.begin_memory_transaction  = 1'b0;
              d.lastRead = !q.ctrl[C_WRITE];
              if (!busErrN)
                d.berr = 1'b1;
              else if (!q.ctrl[C_WRITE])
                d.rdata = dataIn;
            end
          end
          default: d.bs = BS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstnS)
  begin
    if (!rstnS)
    begin
      q <= '0;
      q.bs <= BS_IDLE;
    end
    else
      q <= d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign busClk = q.bclk;
  assign busClkN = !q.bclk;
  assign internal_phase_a = q.bclk;
  assign internal_phase_b = !q.bclk && alignN;
  assign addrOut = q.addr;
  assign dataOut = q.drive;
  assign dataOeN = !(q.dOe && !inReset);
  assign address_strobeN = !(q.address_strobe && q.bclk) || inReset;
  assign byte_lane_enablesN = (q.bs == BS_T1 || q.bs == BS_T2) && !inReset
                              ? ~q.ctrl[C_BE +: 4] : 4'hF;
  assign begin_memory_transactionN = !q.begin_memory_transaction || inReset;
  assign cycle_commit_strobeN = !(q.cycle_commit_strobe && (q.bs == BS_T2 || !q.bclk)) || inReset;
  assign bus_grant_ackN = !q.grant || inReset;
  assign bus_cycle_status = q.st;
  assign cache_block_select = q.ctrl[C_CACHE] && !q.ctrl[C_WRITE] && q.ctrl[C_BLOCK];
  assign writeEnN = !q.ctrl[C_WRITE];
  assign avs_waitrequest = avAcc;

  always_comb
  begin
    case (avs_address)
      A_CTRL:  avs_readdata = q.ctrl;
      A_ADDR:  avs_readdata = q.addr;
      A_WDATA: avs_readdata = q.wdata;
      A_STAT:  avs_readdata = {28'h0, q.grant, q.berr, q.done, q.busy};
      A_RDATA: avs_readdata = q.rdata;
      A_PC:    avs_readdata = q.pc;
      A_GR0:   avs_readdata = q.gr0;
      A_GR1:   avs_readdata = q.gr1;
      A_PSW:   avs_readdata = {16'h0, q.psw};
      A_TSR:   avs_readdata = q.tsr;
      A_TCR:   avs_readdata = q.tcr;
      A_CFG:   avs_readdata = q.cfg;
      A_DCR:   avs_readdata = q.debug_control_register;
      default: avs_readdata = BAD_ADDR_DATA;
    endcase
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstnS);

  chk_align_low_hold: assert property (!alignN |=> !busClk)
    else $error("bus clock not held low");
  chk_align_restart: assert property (alignN && !busClk |=> busClk)
    else $error("bus clock not raised");
  chk_clock_toggle: assert property (alignN |=> busClk != $past(busClk))
    else $error("bus clock did not toggle");
  chk_reset_outputs: assert property (inReset |-> address_strobeN && bus_grant_ackN
    && dataOeN && begin_memory_transactionN && byte_lane_enablesN == 4'hF)
    else $error("outputs active in reset");
  chk_t2_after_t1: assert property (q.bs == BS_T1 && q.cycle_commit_strobe && bclkRise && !inReset
    |=> q.bs == BS_T2)
    else $error("committed cycle skipped second state");
  chk_wait_state: assert property (q.bs == BS_T2 && bclkRise && readyN && !inReset
    |=> q.bs == BS_T2)
    else $error("wait state not inserted");
  chk_cancel_idle: assert property (q.bs == BS_T1 && !q.cycle_commit_strobe && bclkRise && !inReset
    |=> q.bs == BS_IDLE && !q.begin_memory_transaction)
    else $error("cancel did not end cycle");
  chk_pc_cleared: assert property (inReset && bclkRise |=> q.pc == PC_RESET
    && q.cfg == REG_RESET)
    else $error("reset did not clear registers");
  chk_read_write_gap: assert property (q.bs == BS_IDLE && q.lastRead && q.ctrl[C_GO]
    && q.ctrl[C_WRITE] && bclkRise && busReqN && !inReset |=> q.bs == BS_TI)
    else $error("no idle before write");
  chk_strobe_half: assert property (q.bs == BS_T1 && !q.bclk |-> address_strobeN)
    else $error("address strobe past first half");
  chk_write_drive: assert property (q.bs == BS_T1 && bclkFall && q.ctrl[C_WRITE]
    |=> q.dOe && dataOut == $past(q.wdata))
    else $error("write data not driven mid first state");
  chk_read_capture: assert property (q.bs == BS_T2 && bclkRise && !readyN && busErrN
    && !q.ctrl[C_WRITE] && !inReset |=> q.rdata == $past(dataIn))
    else $error("read data not captured");
  chk_error_drop: assert property (q.bs == BS_T2 && bclkRise && !readyN && !busErrN
    && !inReset |=> q.berr && $stable(q.rdata))
    else $error("error read not dropped");

  cov_read_cycle: cover property (q.bs == BS_T2 && !readyN && bclkRise);
  cov_cancel: cover property (q.bs == BS_T1 && !q.cycle_commit_strobe && bclkRise);
  cov_hold: cover property (q.bs == BS_HOLD);
  cov_write_cycle: cover property (q.bs == BS_T2 && !readyN && bclkRise && q.ctrl[C_WRITE]);
  cov_idle_insert: cover property (q.bs == BS_TI);

endmodule // csbi_top
`default_nettype wire

// ==== test/csbi_mem_model.sv ====
// Memory and peripheral side model answering two-state bus cycles
// Assumes busClk and low-active strobes of csbi_top; waits drawn at random
`timescale 1ns/1ps
`default_nettype none
module csbi_mem_model
(
  input  wire  logic        busClk,
  input  wire  logic        address_strobeN,
  input  wire  logic        cycle_commit_strobeN,
  input  wire  logic        writeEnN,
  input  wire  logic [31:0] addrOut,
  input  wire  logic [31:0] dataOut,
  input  wire  logic [4:0]  bus_cycle_status,
  input  wire  logic        errOn,
  output logic              readyN,
  output logic              busErrN,
  output logic [31:0]       dataIn,
  output logic [31:0]       seenAddr,
  output logic [31:0]       seenData,
  output logic [4:0]        seenCode,
  output logic              seenWr,
  output int                doneCnt,
  output int                cancelCnt
);
  logic pend   = 1'b0;
  logic inT2   = 1'b0;
  int   waits;
  initial
  begin
    readyN    = 1'b1;
    busErrN   = 1'b1;
    dataIn    = 32'h5A5A_A5A5;
    doneCnt   = 0;
    cancelCnt = 0;
  end
  // ****************************************
  // Cycle tracking
  // ****************************************
  always @(negedge address_strobeN) pend <= 1'b1;
  always @(negedge busClk)
  begin
    if (pend && !inT2)
    begin
      seenAddr <= addrOut;
      seenCode <= bus_cycle_status;
      seenWr   <= !writeEnN;
    end
    else if (inT2 && seenWr)
      seenData <= dataOut;
  end
  always @(posedge busClk)
  begin
    if (pend && !inT2 && !cycle_commit_strobeN)
    begin
      inT2    <= 1'b1;
      waits = $urandom_range(3, 0);
      readyN  <= (waits != 0);
      busErrN <= !errOn;
      dataIn  <= seenWr ? ~dataIn : seenAddr ^ 32'hC3C3_3C3C;
    end
    else if (pend && !inT2)
    begin
      pend      <= 1'b0;
      cancelCnt <= cancelCnt + 1;
    end
    else if (inT2 && !readyN)
    begin
      inT2    <= 1'b0;
      pend    <= 1'b0;
      readyN  <= 1'b1;
      busErrN <= 1'b1;
      dataIn  <= ~dataIn;
      doneCnt <= doneCnt + 1;
    end
    else if (inT2)
    begin
      waits = waits - 1;
      readyN <= (waits != 0);
    end
    else
      dataIn <= ~dataIn;
  end
endmodule // csbi_mem_model
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for csbi_top with a memory side model
// Assumes csbi_pkg and csbi_mem_model compiled first; clk_sys at 100 MHz
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) bad(g, e); end
module testbench
  import csbi_pkg::*;
;
  logic        clk_sys = 0, rstn = 0, alignN = 1, cpuResetN = 0, busReqN = 1, errOn = 0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 0, avs_write = 0;
  logic [31:0] avs_writedata = 32'h0, lastRd;
  logic        readyN, busErrN, busClk, busClkN, phA, phB, dataOeN, adsN, bmtN, confN;
  logic        hldaN, cbs, weN, avs_waitrequest, seenWr;
  logic [31:0] dataIn, addrOut, dataOut, avs_readdata, seenAddr, seenData;
  logic [3:0]  beN;
  logic [4:0]  st, seenCode;
  int          fail_count = 0, check_count = 0, doneCnt, cancelCnt;
  logic [5:0]  ra[5] = '{A_PC, A_PSW, A_TSR, A_TCR, A_CFG};
  logic [4:0]  codes[14] = '{ST_IACK_M, ST_IACK_C, ST_EOI_M, ST_EOI_C, ST_FETCH_S,
    ST_FETCH_N, ST_DATA, ST_RMW, ST_EAPTR, ST_TE_ONE, ST_TE_TWO, ST_SLV_OPND,
    ST_SLV_STAT, ST_SLV_BCST};

  csbi_top csbi_top_inst (.clk_sys(clk_sys), .rstn(rstn), .alignN(alignN),
    .cpuResetN(cpuResetN), .busReqN(busReqN), .readyN(readyN), .busErrN(busErrN),
    .dataIn(dataIn), .busClk(busClk), .busClkN(busClkN), .internal_phase_a(phA),
    .internal_phase_b(phB), .addrOut(addrOut), .dataOut(dataOut), .dataOeN(dataOeN),
    .address_strobeN(adsN), .byte_lane_enablesN(beN), .begin_memory_transactionN(bmtN),
    .cycle_commit_strobeN(confN), .bus_grant_ackN(hldaN), .bus_cycle_status(st),
    .cache_block_select(cbs), .writeEnN(weN), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  csbi_mem_model csbi_mem_model_inst (.busClk(busClk), .address_strobeN(adsN),
    .cycle_commit_strobeN(confN), .writeEnN(weN), .addrOut(addrOut), .dataOut(dataOut),
    .bus_cycle_status(st), .errOn(errOn), .readyN(readyN), .busErrN(busErrN),
    .dataIn(dataIn), .seenAddr(seenAddr), .seenData(seenData), .seenCode(seenCode),
    .seenWr(seenWr), .doneCnt(doneCnt), .cancelCnt(cancelCnt));

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bad(input logic [31:0] g, input logic [31:0] e);
    fail_count++;
    $display("BAD %0t got %h exp %h", $time, g, e);
  endtask
  task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    rd = avs_readdata;
    if (n >= 64) bad(n, 64);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic busOp(input logic wr, input logic cancel, input logic err,
                       input logic [4:0] code);
    logic [31:0] a, d, s;
    logic [1:0]  idl;
    logic        blk;
    int          c0, x0;
    a = $urandom & 32'hFFFF_FFFC;
    d = $urandom;
    idl = 2'($urandom);
    blk = 1'($urandom);
    c0 = doneCnt;
    x0 = cancelCnt;
    errOn <= err;
    av(1, A_ADDR, a, s);
    av(1, A_WDATA, d, s);
    av(1, A_CTRL, {8'h0F, 6'h0, idl, 3'h0, code, 3'h0, blk, !wr, cancel, wr, 1'b1}, s);
    s = 32'h0;
    for (int n = 0; n < 100 && s[S_DONE] !== 1'b1; n++)
      av(0, A_STAT, 32'h0, s);
    `CHK(s[S_DONE], 1'b1)
    `CHK(cbs, !wr && blk)
    `CHK(s[S_BERR], err)
    `CHK(doneCnt - c0, cancel ? 0 : 1)
    `CHK(cancelCnt - x0, cancel ? 1 : 0)
    if (!cancel)
    begin
      `CHK(seenAddr, a)
      `CHK(seenCode, code)
      `CHK(seenWr, wr)
      if (wr) `CHK(seenData, d)
    end
    av(1, A_STAT, 32'h6, s);
    errOn <= 1'b0;
    av(0, A_RDATA, 32'h0, s);
    if (!wr && !cancel && !err) lastRd = a ^ 32'hC3C3_3C3C;
    if (!wr && !cancel) `CHK(s, lastRd)
    @(negedge clk_sys);
    `CHK(st, {3'h0, idl})
    @(posedge clk_sys);
  endtask
  task automatic cpuRst(input logic req);
    cpuResetN <= 1'b0;
    busReqN <= !req;
    repeat (70) @(posedge busClk);
    @(negedge clk_sys);
    `CHK({adsN, bmtN, confN, hldaN, beN, dataOeN}, 9'h1FF)
    @(posedge clk_sys);
    cpuResetN <= 1'b1;
    for (int n = 0; n < 200 && hldaN !== !req; n++) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({hldaN, adsN}, {!req, 1'b1})
    @(posedge clk_sys);
    busReqN <= 1'b1;
    repeat (20) @(posedge clk_sys);
  endtask
  task automatic regTest();
    logic [31:0] pc, psw, s;
    pc = $urandom;
    psw = $urandom & 32'h0000_FFFF;
    av(1, A_DCR, 32'h1, s);
    av(1, A_TCR, 32'hFFFF_FFFF, s);
    av(1, A_PC, pc, s);
    av(1, A_PSW, psw, s);
    av(0, A_PC, 32'h0, s);
    `CHK(s, pc)
    cpuRst(1);
    av(0, A_GR0, 32'h0, s);
    `CHK(s, pc)
    av(0, A_GR1, 32'h0, s);
    `CHK(s[15:0], psw[15:0])
    foreach (ra[i])
    begin
      av(0, ra[i], 32'h0, s);
      `CHK(s, 32'h0)
    end
    av(0, A_DCR, 32'h0, s);
    `CHK(s[DEN_BIT], 1'b0)
    av(0, 6'h3C, 32'h0, s);
    `CHK(s, BAD_ADDR_DATA)
  endtask
  task automatic alignTest();
    alignN <= 1'b0;
    @(posedge clk_sys);
    repeat (6)
    begin
      @(negedge clk_sys);
      `CHK(busClk, 1'b0)
      @(posedge clk_sys);
    end
    alignN <= 1'b1;
    @(posedge clk_sys);
    for (int k = 0; k < 6; k++)
    begin
      @(negedge clk_sys);
      `CHK(busClk, ~k[0])
      `CHK({busClkN, phA}, {~busClk, busClk})
      `CHK(phB, ~busClk)
      @(posedge clk_sys);
    end
  endtask
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial
  begin
    void'($urandom(58));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cpuRst(0);
    $display("test power-up reset done");
    regTest();
    $display("test register reset done");
    alignTest();
    $display("test clock align done");
    foreach (codes[i]) busOp(1'($urandom), 0, 0, codes[i]);
    $display("test status codes done");
    busOp(0, 0, 0, ST_DATA);
    busOp(0, 0, 1, ST_DATA);
    busOp(1, 0, 0, ST_DATA);
    busOp(1, 0, 0, ST_RMW);
    busOp(0, 1, 0, ST_FETCH_N);
    $display("test error and cancel done");
    repeat (20) busOp(1'($urandom), 1'($urandom % 4 == 0), 0, codes[$urandom % 14]);
    $display("test random cycles done");
    print_verdict();
  end
  initial
  begin
    #500000;
    bad(0, 1);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
